// ==== adc_conversion_config.sv ====
// Converter setup registers, conversion start control and Avalon-MM slave.
`timescale 1ns/1ps

// Functional notes
// - Channel 2 word A: gain 15-11, divider 10-8, resolution 6-4, offset 3 and 2-0.
// - Channel 2 word B: bias 6-4, reference select 1-0, rest unused.
// - Temperature word A: divider 10-8, resolution 6-4, offset 3 and 2-0, no gain.
// - Temperature word B: only bias 6-4; no reference select.
// - Seventeen gain codes are defined; other codes are undefined.
// - Converter clock is the 4 MHz system clock divided by 4 up to 512.
// - Resolution code sets converter clocks per conversion, 256 up to 2048.
// - Coarse offset is applied; its step range follows three gain code ranges.
// - Conversion time is clocks per conversion times the converter clock period.
// - Reference select: 00 supply, 01 external, 10 four times bandgap.
// - Writing a start bit converts that channel, halts the CPU, then self-clears.
module adc_conversion_config
	import adc_setup_pkg::*;
#(
	parameter int TICK_NUM_P = TICK_NUM,
	parameter int TICK_DEN_P = TICK_DEN
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic cpu_halt,
	output logic conv_active,
	output logic conv_done,
	output logic converter_clock_tick,
	output logic conv_channel_ch2,
	output logic [4:0] gain_code,
	output logic gain_code_defined,
	output logic [2:0] divider_code,
	output logic [2:0] resolution_code,
	output logic [3:0] offset_code,
	output logic [1:0] offset_step_range,
	output logic [2:0] bias_code,
	output logic [2:0] vref_source
);

	conv_if cif();

	logic [15:0] ch2_conv_setup_a_r;
	logic [15:0] ch2_conv_setup_b_r;
	logic [15:0] temp_conv_setup_a_r;
	logic [15:0] temp_conv_setup_b_r;
	logic ch2_convert_start_r;
	logic temp_convert_start_r;
	logic res_error_r;
	logic bias_error_r;
	logic [1:0] vref_select_r;
	logic [31:0] readdata_nxt;
	logic [5:0] word_index;
	logic bus_req;
	logic write_go;
	logic start_ch2;
	logic start_temp;
	logic [15:0] sel_setup_a;
	logic [15:0] sel_setup_b;
	logic [2:0] sel_res;
	logic [2:0] sel_div;
	logic [2:0] sel_bias;
	logic sel_res_bad;
	logic sel_bias_bad;
	logic [15:0] ctrl_word;
	logic [15:0] status_word;

	// Merges the two low byte lanes of a bus write into a 16-bit word under a mask.
	function automatic logic [15:0] lane_merge(input logic [15:0] old,
		input logic [31:0] wdata, input logic [3:0] be, input logic [15:0] mask);
		logic [15:0] merged;
		merged = old;
		if (be[0]) begin
			merged[7:0] = wdata[7:0];
		end
		if (be[1]) begin
			merged[15:8] = wdata[15:8];
		end
		return merged & mask;
	endfunction

	conv_timer #(
		.TICK_NUM_P(TICK_NUM_P),
		.TICK_DEN_P(TICK_DEN_P)
	) u_timer (
		.clock(clock),
		.resetn(resetn),
		.bus(cif.tmr)
	);

	// Bus decode: the address is a byte address, so the word index drops the low two bits.
	assign word_index = avs_address[7:2];
	assign bus_req = avs_read || avs_write;
	assign write_go = avs_write && !avs_waitrequest;

	// Avalon handshake: one wait cycle, then waitrequest drops for exactly one cycle.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
		end else if (bus_req && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// Read data is captured with the answer so it stands when waitrequest is low.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= readdata_nxt;
		end
	end

	// Setup words. Writes land on the edge where waitrequest is seen low.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ch2_conv_setup_a_r <= RST_SETUP;
			ch2_conv_setup_b_r <= RST_SETUP;
			temp_conv_setup_a_r <= RST_SETUP;
			temp_conv_setup_b_r <= RST_SETUP;
		end else if (write_go) begin
			if (word_index == IDX_CH2_SETUP_A) begin
				ch2_conv_setup_a_r <= lane_merge(ch2_conv_setup_a_r, avs_writedata,
					avs_byteenable, MASK_CH2_SETUP_A);
			end
			if (word_index == IDX_CH2_SETUP_B) begin
				ch2_conv_setup_b_r <= lane_merge(ch2_conv_setup_b_r, avs_writedata,
					avs_byteenable, MASK_CH2_SETUP_B);
			end
			if (word_index == IDX_TEMP_SETUP_A) begin
				temp_conv_setup_a_r <= lane_merge(temp_conv_setup_a_r, avs_writedata,
					avs_byteenable, MASK_TEMP_SETUP_A);
			end
			if (word_index == IDX_TEMP_SETUP_B) begin
				temp_conv_setup_b_r <= lane_merge(temp_conv_setup_b_r, avs_writedata,
					avs_byteenable, MASK_TEMP_SETUP_B);
			end
		end
	end

	// Channel 2 takes priority when both start bits arrive in one write.
	assign start_ch2 = write_go && word_index == IDX_CONV_CTRL && avs_byteenable[0]
		&& avs_writedata[CH2_START_BIT] && !cpu_halt;
	assign start_temp = write_go && word_index == IDX_CONV_CTRL && avs_byteenable[0]
		&& avs_writedata[TEMP_START_BIT] && !avs_writedata[CH2_START_BIT] && !cpu_halt;

	// Setup of the channel being requested, used to latch the active configuration.
	assign sel_setup_a = start_ch2 ? ch2_conv_setup_a_r : temp_conv_setup_a_r;
	assign sel_setup_b = start_ch2 ? ch2_conv_setup_b_r : temp_conv_setup_b_r;
	assign sel_res = sel_setup_a[RES_LSB +: 3];
	assign sel_div = sel_setup_a[DIV_LSB +: 3];
	assign sel_bias = sel_setup_b[BIAS_LSB +: 3];
	assign sel_res_bad = sel_res == RES_RESERVED;
	assign sel_bias_bad = sel_div < min_div_for_bias(sel_bias);

	// Start bits and CPU halt. A reserved resolution is refused and nothing starts.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ch2_convert_start_r <= 1'b0;
			temp_convert_start_r <= 1'b0;
			cpu_halt <= 1'b0;
			cif.start <= 1'b0;
		end else if ((start_ch2 || start_temp) && !sel_res_bad) begin
			ch2_convert_start_r <= start_ch2;
			temp_convert_start_r <= start_temp;
			cpu_halt <= 1'b1;
			cif.start <= 1'b1;
		end else if (cif.done) begin
			ch2_convert_start_r <= 1'b0;
			temp_convert_start_r <= 1'b0;
			cpu_halt <= 1'b0;
			cif.start <= 1'b0;
		end else begin
			cif.start <= 1'b0;
		end
	end

	// Configuration presented to the analog path, frozen for the whole conversion.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			conv_channel_ch2 <= 1'b0;
			gain_code <= 5'h00;
			gain_code_defined <= 1'b1;
			cif.divider_code <= 3'h0;
			cif.resolution_code <= 3'h0;
			offset_code <= 4'h0;
			offset_step_range <= 2'h0;
			bias_code <= 3'h0;
			vref_select_r <= VREF_SUPPLY;
		end else if ((start_ch2 || start_temp) && !sel_res_bad) begin
			conv_channel_ch2 <= start_ch2;
			gain_code <= start_ch2 ? sel_setup_a[GAIN_LSB +: 5] : 5'h00;
			gain_code_defined <= start_ch2 ? gain_defined(sel_setup_a[GAIN_LSB +: 5]) : 1'b1;
			cif.divider_code <= sel_div;
			cif.resolution_code <= sel_res;
			offset_code <= {sel_setup_a[OFS_SIGN_BIT], sel_setup_a[OFS_MAG_LSB +: 3]};
			offset_step_range <= offset_range(start_ch2 ? sel_setup_a[GAIN_LSB +: 5] : 5'h00);
			bias_code <= sel_bias;
			// The temperature channel has no reference field, so it uses the supply.
			vref_select_r <= start_ch2 ? sel_setup_b[VREF_LSB +: 2] : VREF_SUPPLY;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			vref_source <= 3'h0;
		end else begin
			vref_source <= {vref_select_r == VREF_BANDGAP_X4,
				vref_select_r == VREF_EXTERNAL, vref_select_r == VREF_SUPPLY};
		end
	end

	// Sticky error flags; a new event wins over a software clear in the same cycle.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			res_error_r <= 1'b0;
			bias_error_r <= 1'b0;
		end else begin
			if ((start_ch2 || start_temp) && sel_res_bad) begin
				res_error_r <= 1'b1;
			end else if (write_go && word_index == IDX_CONV_STATUS && avs_byteenable[0]
				&& avs_writedata[ST_RES_ERR_BIT]) begin
				res_error_r <= 1'b0;
			end
			if ((start_ch2 || start_temp) && !sel_res_bad && sel_bias_bad) begin
				bias_error_r <= 1'b1;
			end else if (write_go && word_index == IDX_CONV_STATUS && avs_byteenable[0]
				&& avs_writedata[ST_BIAS_ERR_BIT]) begin
				bias_error_r <= 1'b0;
			end
		end
	end

	// Timer state mirrored to the pins through flops of their own.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			conv_active <= 1'b0;
			conv_done <= 1'b0;
			converter_clock_tick <= 1'b0;
		end else begin
			conv_active <= cif.busy;
			conv_done <= cif.done;
			converter_clock_tick <= cif.adc_tick;
		end
	end

	assign divider_code = cif.divider_code;
	assign resolution_code = cif.resolution_code;

	// Read views of the control and status words.
	always_comb begin
		ctrl_word = 16'h0000;
		ctrl_word[CH2_START_BIT] = ch2_convert_start_r;
		ctrl_word[TEMP_START_BIT] = temp_convert_start_r;
		status_word = 16'h0000;
		status_word[ST_BUSY_BIT] = cpu_halt;
		status_word[ST_CH2_BIT] = conv_channel_ch2;
		status_word[ST_RES_ERR_BIT] = res_error_r;
		status_word[ST_BIAS_ERR_BIT] = bias_error_r;
		status_word[ST_RANGE_LSB +: 2] = offset_step_range;
	end

	// Read mux; unmapped words read as zero.
	always_comb begin
		readdata_nxt = 32'h0000_0000;
		unique case (word_index)
			IDX_CONV_CTRL: readdata_nxt = {16'h0000, ctrl_word};
			IDX_CH2_SETUP_A: readdata_nxt = {16'h0000, ch2_conv_setup_a_r};
			IDX_CH2_SETUP_B: readdata_nxt = {16'h0000, ch2_conv_setup_b_r};
			IDX_TEMP_SETUP_A: readdata_nxt = {16'h0000, temp_conv_setup_a_r};
			IDX_TEMP_SETUP_B: readdata_nxt = {16'h0000, temp_conv_setup_b_r};
			IDX_CONV_STATUS: readdata_nxt = {16'h0000, status_word};
			default: readdata_nxt = 32'h0000_0000;
		endcase
	end

endmodule

// ==== adc_setup_pkg.sv ====
// Shared constants, field layouts and decode functions for the converter setup block.
package adc_setup_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [5:0] IDX_CONV_CTRL = 6'h00;
	localparam logic [5:0] IDX_CH2_SETUP_A = 6'h05;
	localparam logic [5:0] IDX_CH2_SETUP_B = 6'h06;
	localparam logic [5:0] IDX_TEMP_SETUP_A = 6'h08;
	localparam logic [5:0] IDX_TEMP_SETUP_B = 6'h09;
	localparam logic [5:0] IDX_CONV_STATUS = 6'h0a;

	// Writable bits of each setup word; unused bits stay zero.
	localparam logic [15:0] MASK_CH2_SETUP_A = 16'hff7f;
	localparam logic [15:0] MASK_CH2_SETUP_B = 16'h0073;
	localparam logic [15:0] MASK_TEMP_SETUP_A = 16'h077f;
	localparam logic [15:0] MASK_TEMP_SETUP_B = 16'h0070;
	localparam logic [15:0] RST_SETUP = 16'h0000;

	// Field positions inside the setup words.
	localparam int GAIN_LSB = 11;
	localparam int DIV_LSB = 8;
	localparam int RES_LSB = 4;
	localparam int OFS_SIGN_BIT = 3;
	localparam int OFS_MAG_LSB = 0;
	localparam int BIAS_LSB = 4;
	localparam int VREF_LSB = 0;

	// Control register start bits.
	localparam int CH2_START_BIT = 1;
	localparam int TEMP_START_BIT = 0;

	// Status register bit positions.
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_CH2_BIT = 1;
	localparam int ST_RES_ERR_BIT = 2;
	localparam int ST_BIAS_ERR_BIT = 3;
	localparam int ST_RANGE_LSB = 4;

	// Resolution code that has no clock count and is refused.
	localparam logic [2:0] RES_RESERVED = 3'h7;

	// Reference select codes.
	localparam logic [1:0] VREF_SUPPLY = 2'h0;
	localparam logic [1:0] VREF_EXTERNAL = 2'h1;
	localparam logic [1:0] VREF_BANDGAP_X4 = 2'h2;

	// Gain code limits of the three coarse offset step ranges.
	localparam logic [4:0] GAIN_RANGE0_TOP = 5'h08;
	localparam logic [4:0] GAIN_RANGE1_TOP = 5'h10;
	localparam logic [4:0] GAIN_RANGE2_TOP = 5'h1e;

	// System clock and core clock rates; the ratio paces the converter clock.
	localparam int SYS_CLK_HZ = 4000000;
	localparam int CORE_CLK_HZ = 250000000;
	localparam int TICK_NUM = SYS_CLK_HZ / 2000000;
	localparam int TICK_DEN = CORE_CLK_HZ / 2000000;

	// Channel that a conversion serves.
	typedef enum logic {CHAN_TEMP, CHAN_CH2} conv_chan_t;

	// Divisor minus one of the system clock for a divider code (4 .. 512).
	function automatic logic [8:0] div_last(input logic [2:0] code);
		logic [9:0] divisor;
		divisor = 10'h004 << code;
		return 9'(divisor - 10'h001);
	endfunction

	// Converter clocks per conversion minus one for a resolution code.
	function automatic logic [10:0] clocks_last(input logic [2:0] code);
		logic [10:0] last;
		last = 11'h0ff;
		unique case (code)
			3'h0: last = 11'h0ff;
			3'h1: last = 11'h13f;
			3'h2: last = 11'h1ff;
			3'h3: last = 11'h27f;
			3'h4: last = 11'h31f;
			3'h5: last = 11'h4ff;
			3'h6: last = 11'h7ff;
			3'h7: last = 11'h7ff;
		endcase
		return last;
	endfunction

	// True for the seventeen gain codes that have a defined gain.
	function automatic logic gain_defined(input logic [4:0] code);
		return (code <= GAIN_RANGE0_TOP) || (code[0] == 1'b0 && (code <= 5'h10
			|| code == 5'h14 || code >= 5'h18) && code != 5'h1a && code != 5'h1e)
			|| code == GAIN_RANGE2_TOP;
	endfunction

	// Coarse offset step range chosen by the gain code.
	function automatic logic [1:0] offset_range(input logic [4:0] code);
		if (code <= GAIN_RANGE0_TOP) begin
			return 2'h0;
		end else if (code <= GAIN_RANGE1_TOP) begin
			return 2'h1;
		end
		return 2'h2;
	endfunction

	// Fastest-permitted check: lowest divider code the bias setting allows.
	function automatic logic [2:0] min_div_for_bias(input logic [2:0] bias);
		return 3'h3 - {1'b0, bias[2:1]};
	endfunction

endpackage

// ==== conv_if.sv ====
// Signals between the register side and the conversion timer.
`timescale 1ns/1ps
interface conv_if;
	logic start;
	logic [2:0] divider_code;
	logic [2:0] resolution_code;
	logic busy;
	logic adc_tick;
	logic done;
	modport ctl(output start, output divider_code, output resolution_code,
		input busy, input adc_tick, input done);
	modport tmr(input start, input divider_code, input resolution_code,
		output busy, output adc_tick, output done);
endinterface

// ==== conv_timer.sv ====
// Converter clock generation and conversion length counter.
`timescale 1ns/1ps
module conv_timer
	import adc_setup_pkg::*;
#(
	parameter int TICK_NUM_P = TICK_NUM,
	parameter int TICK_DEN_P = TICK_DEN
) (
	input wire logic clock,
	input wire logic resetn,
	conv_if.tmr bus
);

	logic [7:0] acc_r;
	logic [8:0] acc_sum;
	logic sys_tick;
	logic [8:0] div_cnt_r;
	logic [10:0] conv_cnt_r;

	// A fractional accumulator turns the core clock into exact system clock ticks.
	assign acc_sum = 9'(acc_r) + 9'(TICK_NUM_P);
	assign sys_tick = acc_sum >= 9'(TICK_DEN_P);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			acc_r <= 8'h00;
		end else if (bus.start) begin
			acc_r <= 8'h00;
		end else if (sys_tick) begin
			acc_r <= 8'(acc_sum - 9'(TICK_DEN_P));
		end else begin
			acc_r <= acc_sum[7:0];
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			div_cnt_r <= 9'h000;
			bus.adc_tick <= 1'b0;
		end else if (bus.start || !bus.busy) begin
			div_cnt_r <= 9'h000;
			bus.adc_tick <= 1'b0;
		end else if (sys_tick) begin
			bus.adc_tick <= div_cnt_r == div_last(bus.divider_code);
			div_cnt_r <= (div_cnt_r == div_last(bus.divider_code)) ? 9'h000 : div_cnt_r + 9'h001;
		end else begin
			bus.adc_tick <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			conv_cnt_r <= 11'h000;
			bus.busy <= 1'b0;
			bus.done <= 1'b0;
		end else if (bus.start) begin
			conv_cnt_r <= 11'h000;
			bus.busy <= 1'b1;
			bus.done <= 1'b0;
		end else if (bus.busy && bus.adc_tick) begin
			if (conv_cnt_r == clocks_last(bus.resolution_code)) begin
				bus.busy <= 1'b0;
				bus.done <= 1'b1;
			end else begin
				conv_cnt_r <= conv_cnt_r + 11'h001;
				bus.done <= 1'b0;
			end
		end else begin
			bus.done <= 1'b0;
		end
	end

endmodule

// ==== adc_conversion_config_properties.sv ====
// Concurrent checks on the ports of the converter setup block.
`timescale 1ns/1ps
module adc_conversion_config_properties
	import adc_setup_pkg::*;
#(
	parameter int TICK_NUM_P = TICK_NUM,
	parameter int TICK_DEN_P = TICK_DEN
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic cpu_halt,
	input wire logic conv_active,
	input wire logic conv_done,
	input wire logic converter_clock_tick,
	input wire logic conv_channel_ch2,
	input wire logic [4:0] gain_code,
	input wire logic gain_code_defined,
	input wire logic [2:0] divider_code,
	input wire logic [2:0] resolution_code,
	input wire logic [3:0] offset_code,
	input wire logic [1:0] offset_step_range,
	input wire logic [2:0] bias_code,
	input wire logic [2:0] vref_source
);
	// One bit per gain code that has a defined gain.
	localparam logic [31:0] GAIN_OK = 32'h511155ff;
	logic [11:0] tick_cnt_r;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	// Converter ticks of the running conversion; the done pulse clears the count.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			tick_cnt_r <= 12'h000;
		end else if (conv_done) begin
			tick_cnt_r <= 12'h000;
		end else if (converter_clock_tick && conv_active) begin
			tick_cnt_r <= tick_cnt_r + 12'h001;
		end
	end

	// Clocks per conversion, written out apart from the design's own table.
	function automatic logic [11:0] clocks_of(input logic [2:0] code);
		case (code)
			3'h0: return 12'h100;
			3'h1: return 12'h140;
			3'h2: return 12'h200;
			3'h3: return 12'h280;
			3'h4: return 12'h320;
			3'h5: return 12'h500;
			default: return 12'h800;
		endcase
	endfunction

	// Bus answers come one cycle after the request and stand for one cycle only.
	chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest stayed low for more than one cycle");
	chk_answer_prompt: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered in the next cycle");
	// start comes from a control write.
	chk_halt_cause: assert property ($rose(cpu_halt) |-> $past(avs_write) && !$past(avs_waitrequest))
		else $error("cpu halt rose without a completed write");
	chk_halt_done: assert property ($fell(cpu_halt) |-> ##[0:2] conv_done)
		else $error("halt ended without a done pulse");
	chk_done_pulse: assert property (conv_done |=> !conv_done)
		else $error("done pulse longer than one cycle");
	chk_reserved_res: assert property (cpu_halt |-> resolution_code != 3'h7)
		else $error("conversion running with reserved resolution");
	chk_gain_flag: assert property (gain_code_defined == GAIN_OK[gain_code])
		else $error("gain defined flag does not match gain code");
	chk_offset_range: assert property (offset_step_range == ((gain_code <= 5'h08) ? 2'h0 :
		(gain_code <= 5'h10) ? 2'h1 : 2'h2))
		else $error("offset step range does not follow gain code");
	chk_temp_setup: assert property (conv_active && !conv_channel_ch2 |->
		vref_source == 3'h1 && gain_code == 5'h00)
		else $error("temperature conversion with gain or reference set");
	chk_tick_count: assert property (conv_done |-> tick_cnt_r == clocks_of(resolution_code))
		else $error("converter clock count wrong at completion");
	chk_tick_period: assert property (converter_clock_tick && conv_active && divider_code == 3'h0
		&& TICK_NUM_P == TICK_DEN_P |=> !converter_clock_tick [*3])
		else $error("converter ticks closer than the divisor");

	cov_ch2_done: cover property (conv_done && conv_channel_ch2);
	cov_temp_done: cover property (conv_done && !conv_channel_ch2);
	cov_read: cover property (avs_read && !avs_waitrequest);
endmodule

// ==== adc_conversion_config_test.sv ====
// Self-checking bench for the converter setup block.
`timescale 1ns/1ps
module adc_conversion_config_test
	import adc_setup_pkg::*;
;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'h3;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, cpu_halt, conv_active, conv_done, converter_clock_tick;
	logic conv_channel_ch2, gain_code_defined;
	logic [4:0] gain_code;
	logic [2:0] divider_code, resolution_code, bias_code, vref_source;
	logic [3:0] offset_code;
	logic [1:0] offset_step_range;
	int error_cnt = 0;
	int check_count = 0;
	int cyc = 0;
	int ticks = 0;
	int clk_tab [7] = '{256, 320, 512, 640, 800, 1280, 2048};
	logic [5:0] idx_tab [5] = '{IDX_CH2_SETUP_A, IDX_CH2_SETUP_B, IDX_TEMP_SETUP_A,
		IDX_TEMP_SETUP_B, 6'h07};
	logic [15:0] mask_tab [5] = '{MASK_CH2_SETUP_A, MASK_CH2_SETUP_B, MASK_TEMP_SETUP_A,
		MASK_TEMP_SETUP_B, 16'h0000};

	// One system tick per core cycle keeps conversions short.
	adc_conversion_config #(.TICK_NUM_P(1), .TICK_DEN_P(1)) i_adc_conversion_config (
		.clock(clock), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_halt(cpu_halt),
		.conv_active(conv_active), .conv_done(conv_done),
		.converter_clock_tick(converter_clock_tick), .conv_channel_ch2(conv_channel_ch2),
		.gain_code(gain_code), .gain_code_defined(gain_code_defined),
		.divider_code(divider_code), .resolution_code(resolution_code),
		.offset_code(offset_code), .offset_step_range(offset_step_range),
		.bias_code(bias_code), .vref_source(vref_source));

	// Free-running clock at 250 MHz.
	always #2 clock = ~clock;

	// Cycle count and converter ticks seen while the timer runs.
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (conv_active === 1'b1 && converter_clock_tick === 1'b1) begin
			ticks <= ticks + 1;
		end
	end

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One Avalon access; the request is held until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] wd,
		output logic [31:0] rd);
		@(posedge clock);
		avs_address <= {idx, 2'h0};
		avs_writedata <= {16'h0000, wd};
		avs_write <= wr;
		avs_read <= !wr;
		// Only the watchdog ends a wait that never gets an answer.
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [15:0] d);
		logic [31:0] x;
		bus(1'b1, idx, d, x);
	endtask

	task automatic rd_chk(input logic [5:0] idx, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, idx, 16'h0000, x);
		check(x & m, e);
	endtask

	// Full conversion: setup, start, latched outputs, length and self-clear.
	task automatic run_conv(input logic ch2, input logic [15:0] a, input logic [15:0] b,
		input logic def, input logic [1:0] rng, input logic [2:0] vref);
		int t0;
		int ecyc;
		ecyc = clk_tab[a[6:4]] * (4 << a[10:8]);
		wr(ch2 ? IDX_CH2_SETUP_A : IDX_TEMP_SETUP_A, a);
		wr(ch2 ? IDX_CH2_SETUP_B : IDX_TEMP_SETUP_B, b);
		ticks = 0;
		wr(IDX_CONV_CTRL, ch2 ? 16'h0002 : 16'h0001);
		t0 = cyc;
		rd_chk(IDX_CONV_CTRL, 32'hffff_ffff, ch2 ? 32'h2 : 32'h1);
		check(32'({conv_channel_ch2, cpu_halt, gain_code, gain_code_defined}),
			32'({ch2, 1'b1, ch2 ? a[15:11] : 5'h00, def}));
		check(32'({divider_code, resolution_code, offset_code, bias_code}),
			32'({a[10:8], a[6:4], a[3:0], b[6:4]}));
		check(32'({offset_step_range, vref_source}), 32'({rng, vref}));
		do begin
			@(posedge clock);
		end while (conv_done !== 1'b1 && cyc - t0 < 40000);
		check(32'(cyc - t0 >= ecyc && cyc - t0 <= ecyc + 4), 32'h1);
		rd_chk(IDX_CONV_CTRL, 32'hffff_ffff, 32'h0);
		check(32'({cpu_halt, 12'(ticks)}), 32'(clk_tab[a[6:4]]));
	endtask

	// Watchdog sized well above the longest expected run.
	initial begin
		repeat (40000) @(posedge clock);
		error_cnt++;
		end_of_test();
	end

	// Main sequence.
	initial begin
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		// reset values, writable bits, unmapped place.
		for (int i = 0; i < 5; i++) begin
			rd_chk(idx_tab[i], 32'hffff_ffff, 32'h0);
		end
		for (int i = 0; i < 5; i++) begin
			wr(idx_tab[i], 16'hffff);
		end
		for (int i = 0; i < 5; i++) begin
			rd_chk(idx_tab[i], 32'hffff_ffff, {16'h0000, mask_tab[i]});
		end
		// gain boundaries and reference codes 00, 10 and 11.
		run_conv(1'b1, 16'h5009, 16'h0072, 1'b1, 2'h1, 3'h4);
		run_conv(1'b0, 16'hf913, 16'h0073, 1'b1, 2'h0, 3'h1);
		run_conv(1'b1, 16'h8000, 16'h0063, 1'b1, 2'h1, 3'h0);
		run_conv(1'b1, 16'h4000, 16'h0070, 1'b1, 2'h0, 3'h1);
		rd_chk(IDX_CONV_STATUS, 32'hc, 32'h0);
		// slow bias with fastest clock is flagged; undefined gain only flagged.
		run_conv(1'b1, 16'hf82f, 16'h0001, 1'b0, 2'h2, 3'h2);
		rd_chk(IDX_CONV_STATUS, 32'h8, 32'h8);
		wr(IDX_CONV_STATUS, 16'h000c);
		rd_chk(IDX_CONV_STATUS, 32'hc, 32'h0);
		wr(IDX_CH2_SETUP_A, 16'h0070);
		wr(IDX_CONV_CTRL, 16'h0002);
		repeat (3) @(posedge clock);
		check(32'(cpu_halt), 32'h0);
		rd_chk(IDX_CONV_STATUS, 32'h4, 32'h4);
		end_of_test();
	end
endmodule

bind adc_conversion_config adc_conversion_config_properties #(.TICK_NUM_P(TICK_NUM_P),
	.TICK_DEN_P(TICK_DEN_P)) i_adc_conversion_config_properties (.*);
